// File: design/bcp_map.vh
// register map, field positions, reset values and timing counts of the
// commutation and pwm control block; assumes a 250 MHz system clock
`ifndef BCP_MAP_VH
`define BCP_MAP_VH

`define BCP_ADDR_COMM 8'h16
`define BCP_ADDR_GATE 8'h17
`define BCP_COMM_RESET 8'h00
`define BCP_GATE_RESET 8'h00

`define BCP_SLOPE_BIT 7
`define BCP_ANGLE_HI 6
`define BCP_ANGLE_LO 5
`define BCP_CARRIER_FREQUENCY_CODE_HI 4
`define BCP_CARRIER_FREQUENCY_CODE_LO 2
`define BCP_DT_HI 1
`define BCP_DT_LO 0
`define BCP_OCP_BIT 6
`define BCP_SRC_HI 5
`define BCP_SRC_LO 3
`define BCP_SNK_HI 2
`define BCP_SNK_LO 0

`define BCP_CLK_PERIOD_NS 4
`define BCP_T_STEP_FAST_US 2700
`define BCP_T_STEP_SLOW_US 10800
`define BCP_STEP_FAST_CYC (`BCP_T_STEP_FAST_US * 1000 / `BCP_CLK_PERIOD_NS)
`define BCP_STEP_SLOW_CYC (`BCP_T_STEP_SLOW_US * 1000 / `BCP_CLK_PERIOD_NS)
`define BCP_INT_CLK_DIV 21

`define BCP_DT_TICKS_0 5'd3
`define BCP_DT_TICKS_1 5'd6
`define BCP_DT_TICKS_2 5'd12
`define BCP_DT_TICKS_3 5'd18

`define BCP_BAND_HZ 16'd200
`define BCP_HYST_HZ 16'd100
`define BCP_LEAD_MAX_120 3'd4
`define BCP_LEAD_MAX_135 3'd3
`define BCP_LEAD_MAX_150 3'd2
`define BCP_FULL_DUTY 10'd512

`endif

// File: design/bcp_ctrl.v
// commutation, duty slew, carrier and dead-time control of a sensorless
// three-phase predriver; inputs are synchronous to clk_sys
`timescale 1ns/1ns
`include "bcp_map.vh"

module bcp_ctrl #(
    parameter STEP_FAST_CYC = `BCP_STEP_FAST_CYC,
    parameter STEP_SLOW_CYC = `BCP_STEP_SLOW_CYC,
    parameter INT_DIV = `BCP_INT_CLK_DIV
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire [1:0] phase_state,
    input wire closed_loop,
    input wire [9:0] duty_target,
    input wire [2:0] duty_step_limit,
    input wire [2:0] ss_duty_step_limit,
    input wire duty_up_slow,
    input wire [15:0] elec_freq_hz,
    input wire [2:0] comm_step,
    input wire comm_event,
    input wire [2:0] lead_angle_req,
    input wire rotation_direction_pin,
    input wire dir_invert,
    input wire brake_pin,
    input wire brake_polarity,
    input wire auto_dead_time_disable,
    output reg [2:0] gate_hi,
    output reg [2:0] gate_lo,
    output reg [9:0] duty_out,
    output reg [2:0] lead_angle_eff,
    output reg [1:0] comm_angle_sel,
    output reg soft_switch_on,
    output reg dir_ccw,
    output reg brake_on,
    output reg dead_time_active,
    output reg [1:0] carrier_div_sel,
    output reg [2:0] speed_band,
    output reg [2:0] gate_source_code,
    output reg [2:0] gate_sink_code,
    output reg current_limit_level,
    output reg monitor_gain_sel
);

localparam PH_IDLE = 2'd0;
localparam PH_START = 2'd1;
localparam PH_RUN = 2'd2;

localparam ANG_120 = 2'd0;
localparam ANG_135 = 2'd1;
localparam ANG_1425 = 2'd2;
localparam ANG_150 = 2'd3;

reg [7:0] comm_cfg_reg;
reg [7:0] gate_cfg_reg;
reg [21:0] step_cnt_reg;
reg [12:0] duty_acc_reg;
reg [4:0] int_cnt_reg;
reg [8:0] car_cnt_reg;
reg [3:0] ramp_reg;
reg [4:0] dt_cnt_reg;

// duty step per interval, in eighths of 1/512
function [6:0] step_of;
    input [2:0] code;
    begin
        case (code)
            3'd1: step_of = 7'd2;
            3'd2: step_of = 7'd3;
            3'd3: step_of = 7'd4;
            3'd4: step_of = 7'd6;
            3'd5: step_of = 7'd10;
            3'd6: step_of = 7'd20;
            3'd7: step_of = 7'd56;
            default: step_of = 7'd64;
        endcase
    end
endfunction

// divide select: 0=512, 1=256, 2=128, 3=64
function [1:0] carrier_of;
    input [2:0] code;
    input [2:0] band;
    begin
        case (code)
            3'd4: carrier_of = (band == 3'd5) ? 2'd3 : (band >= 3'd2) ? 2'd2 : 2'd1;
            3'd5: carrier_of = (band == 3'd0) ? 2'd0 : (band == 3'd1) ? 2'd1 : 2'd2;
            3'd6: carrier_of = (band >= 3'd4) ? 2'd2 : (band >= 3'd2) ? 2'd1 : 2'd0;
            3'd7: carrier_of = (band >= 3'd4) ? 2'd3 : (band >= 3'd2) ? 2'd2 : band[1:0];
            default: carrier_of = code[1:0];
        endcase
    end
endfunction

// one-hot {high side, low side} of each six-step state
function [5:0] sixstep;
    input [2:0] s;
    begin
        case (s)
            3'd0: sixstep = {3'b001, 3'b010};
            3'd1: sixstep = {3'b001, 3'b100};
            3'd2: sixstep = {3'b010, 3'b100};
            3'd3: sixstep = {3'b010, 3'b001};
            3'd4: sixstep = {3'b100, 3'b001};
            3'd5: sixstep = {3'b100, 3'b010};
            default: sixstep = 6'd0;
        endcase
    end
endfunction

wire [1:0] angle_code = comm_cfg_reg[`BCP_ANGLE_HI:`BCP_ANGLE_LO];
wire slope_select = comm_cfg_reg[`BCP_SLOPE_BIT];
wire [2:0] carrier_frequency_code_code = comm_cfg_reg[`BCP_CARRIER_FREQUENCY_CODE_HI:`BCP_CARRIER_FREQUENCY_CODE_LO];
wire [1:0] dt_code = comm_cfg_reg[`BCP_DT_HI:`BCP_DT_LO];

wire starting = (phase_state == PH_START);
wire [21:0] interval = (starting || !duty_up_slow) ? STEP_FAST_CYC[21:0] : STEP_SLOW_CYC[21:0];
wire step_tick = (step_cnt_reg >= interval - 22'd1);
wire int_tick = (int_cnt_reg == INT_DIV[4:0] - 5'd1);
wire [8:0] car_period = 9'h1ff >> carrier_div_sel;
wire car_wrap = int_tick && (car_cnt_reg >= car_period);

wire [12:0] target8 = {duty_target, 3'b000};
wire [6:0] step_amt = starting ? step_of(ss_duty_step_limit) : step_of(duty_step_limit);
wire no_limit = (phase_state == PH_RUN) && !closed_loop && (duty_step_limit == 3'd0);
wire [12:0] diff_up = target8 - duty_acc_reg;
wire [12:0] diff_dn = duty_acc_reg - target8;
reg [12:0] duty_next;

always @* begin
    duty_next = duty_acc_reg;
    if (phase_state == PH_IDLE) begin
        duty_next = 13'd0;
    end else if (no_limit) begin
        duty_next = target8;
    end else if (step_tick) begin
        if (duty_acc_reg < target8) begin
            duty_next = (diff_up > {6'd0, step_amt}) ? duty_acc_reg + {6'd0, step_amt} : target8;
        end else begin
            duty_next = (diff_dn > {6'd0, step_amt}) ? duty_acc_reg - {6'd0, step_amt} : target8;
        end
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        step_cnt_reg <= 22'd0;
        duty_acc_reg <= 13'd0;
        duty_out <= 10'd0;
    end else begin
        step_cnt_reg <= step_tick ? 22'd0 : step_cnt_reg + 22'd1;
        duty_acc_reg <= duty_next;
        duty_out <= duty_next[12:3];
    end
end

// register port
always @(posedge clk_sys) begin
    if (rst) begin
        comm_cfg_reg <= `BCP_COMM_RESET;
        gate_cfg_reg <= `BCP_GATE_RESET;
        reg_rdata <= 8'h00;
    end else begin
        if (reg_wr && reg_addr == `BCP_ADDR_COMM) begin
            comm_cfg_reg <= reg_wdata;
        end
        if (reg_wr && reg_addr == `BCP_ADDR_GATE) begin
            gate_cfg_reg <= {1'b0, reg_wdata[6:0]};
        end
        case (reg_addr)
            `BCP_ADDR_COMM: reg_rdata <= comm_cfg_reg;
            `BCP_ADDR_GATE: reg_rdata <= gate_cfg_reg;
            default: reg_rdata <= 8'h00;
        endcase
    end
end

// commutation angle, soft switching and lead clamp
always @(posedge clk_sys) begin
    if (rst) begin
        comm_angle_sel <= ANG_120;
        soft_switch_on <= 1'b0;
        lead_angle_eff <= 3'd0;
        gate_source_code <= 3'd0;
        gate_sink_code <= 3'd0;
        current_limit_level <= 1'b0;
        monitor_gain_sel <= 1'b0;
    end else begin
        case (angle_code)
            2'd0: comm_angle_sel <= ANG_120;
            2'd1: comm_angle_sel <= ANG_135;
            2'd2: comm_angle_sel <= ANG_150;
            default: comm_angle_sel <= slope_select ? ANG_150 : ANG_1425;
        endcase
        soft_switch_on <= !slope_select && (angle_code != 2'd0);
        case (angle_code)
            2'd0: lead_angle_eff <= (lead_angle_req > `BCP_LEAD_MAX_120) ? `BCP_LEAD_MAX_120 : lead_angle_req;
            2'd1: lead_angle_eff <= (lead_angle_req > `BCP_LEAD_MAX_135) ? `BCP_LEAD_MAX_135 : lead_angle_req;
            default: lead_angle_eff <= (lead_angle_req > `BCP_LEAD_MAX_150) ? `BCP_LEAD_MAX_150 : lead_angle_req;
        endcase
        gate_source_code <= gate_cfg_reg[`BCP_SRC_HI:`BCP_SRC_LO];
        gate_sink_code <= gate_cfg_reg[`BCP_SNK_HI:`BCP_SNK_LO];
        current_limit_level <= gate_cfg_reg[`BCP_OCP_BIT];
        monitor_gain_sel <= gate_cfg_reg[`BCP_OCP_BIT];
    end
end

// speed band with hysteresis
wire [15:0] band_up_edge = `BCP_BAND_HZ * {13'd0, speed_band + 3'd1};
wire [15:0] band_dn_edge = `BCP_BAND_HZ * {13'd0, speed_band} - `BCP_HYST_HZ;

always @(posedge clk_sys) begin
    if (rst) begin
        speed_band <= 3'd0;
    end else if (speed_band < 3'd5 && elec_freq_hz > band_up_edge) begin
        speed_band <= speed_band + 3'd1;
    end else if (speed_band > 3'd0 && elec_freq_hz <= band_dn_edge) begin
        speed_band <= speed_band - 3'd1;
    end
end

// internal clock and carrier
always @(posedge clk_sys) begin
    if (rst) begin
        int_cnt_reg <= 5'd0;
        car_cnt_reg <= 9'd0;
        carrier_div_sel <= 2'd0;
    end else begin
        int_cnt_reg <= int_tick ? 5'd0 : int_cnt_reg + 5'd1;
        if (car_wrap) begin
            car_cnt_reg <= 9'd0;
            carrier_div_sel <= carrier_of(carrier_frequency_code_code, speed_band);
        end else if (int_tick) begin
            car_cnt_reg <= car_cnt_reg + 9'd1;
        end
    end
end

// soft switching ramp in carrier periods
always @(posedge clk_sys) begin
    if (rst) begin
        ramp_reg <= 4'd8;
    end else if (comm_event && soft_switch_on) begin
        ramp_reg <= 4'd1;
    end else if (car_wrap && ramp_reg < 4'd8) begin
        ramp_reg <= ramp_reg + 4'd1;
    end
end

wire [13:0] duty_scaled = duty_out * ramp_reg;
wire [9:0] duty_eff = duty_scaled[12:3];
wire [9:0] car_pos = {1'b0, car_cnt_reg << carrier_div_sel};
wire pwm_on = (car_pos < duty_eff);

// direction and brake requests, dead time
// direction mapping
wire ccw_req = rotation_direction_pin ^ dir_invert;
wire brake_req = brake_pin ^ brake_polarity;
wire need_dt = (brake_req && !brake_on) || (ccw_req != dir_ccw);
wire dt_start = need_dt && !auto_dead_time_disable;
reg [4:0] dt_load;

always @* begin
    case (dt_code)
        2'd0: dt_load = `BCP_DT_TICKS_0;
        2'd1: dt_load = `BCP_DT_TICKS_1;
        2'd2: dt_load = `BCP_DT_TICKS_2;
        default: dt_load = `BCP_DT_TICKS_3;
    endcase
end

always @(posedge clk_sys) begin
    if (rst) begin
        dir_ccw <= 1'b0;
        brake_on <= 1'b0;
        dead_time_active <= 1'b0;
        dt_cnt_reg <= 5'd0;
    end else if (dead_time_active) begin
        if (int_tick && dt_cnt_reg <= 5'd1) begin
            dead_time_active <= 1'b0;
            brake_on <= brake_req;
            dir_ccw <= ccw_req;
        end else if (int_tick) begin
            dt_cnt_reg <= dt_cnt_reg - 5'd1;
        end
    end else if (need_dt && !auto_dead_time_disable) begin
        dead_time_active <= 1'b1;
        dt_cnt_reg <= dt_load;
    end else begin
        brake_on <= brake_req;
        dir_ccw <= ccw_req;
    end
end

// gate drive
wire [5:0] hl = sixstep(comm_step);
wire [2:0] hi_sel = dir_ccw ? hl[2:0] : hl[5:3];
wire [2:0] lo_sel = dir_ccw ? hl[5:3] : hl[2:0];

always @(posedge clk_sys) begin
    if (rst) begin
        gate_hi <= 3'b000;
        gate_lo <= 3'b000;
    end else if (dead_time_active || dt_start || (phase_state == PH_IDLE && !brake_on)) begin
        gate_hi <= 3'b000;
        gate_lo <= 3'b000;
    end else if (brake_on) begin
        gate_hi <= 3'b000;
        gate_lo <= 3'b111;
    end else begin
        gate_hi <= hi_sel & {3{pwm_on}};
        gate_lo <= lo_sel;
    end
end

endmodule

// File: tb/bcp_ctrl_sva.sv
// port-level checker for the commutation and pwm control block
// assumes rst is synchronous, active high, on clk_sys
`timescale 1ns/1ns
module bcp_ctrl_chk (
    input wire clk_sys,
    input wire rst,
    input wire brake_pin,
    input wire brake_polarity,
    input wire auto_dead_time_disable,
    input wire rotation_direction_pin,
    input wire dir_invert,
    input wire [2:0] gate_hi,
    input wire [2:0] gate_lo,
    input wire [2:0] lead_angle_eff,
    input wire [1:0] comm_angle_sel,
    input wire dir_ccw,
    input wire brake_on,
    input wire dead_time_active,
    input wire current_limit_level,
    input wire monitor_gain_sel
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire brk_req = brake_pin ^ brake_polarity;
    property p_gain; monitor_gain_sel == current_limit_level; endproperty
    a_gain: assert property (p_gain) else $error("gain differs from limit level");
    property p_dt_gates; dead_time_active |-> gate_hi == 3'h0 && gate_lo == 3'h0; endproperty
    a_dt_gates: assert property (p_dt_gates) else $error("gate on in dead time");
    property p_dt_start;
        $rose(brk_req) && !auto_dead_time_disable && !dead_time_active && !brake_on |=> dead_time_active;
    endproperty
    a_dt_start: assert property (p_dt_start) else $error("no dead time on brake");
    property p_brk_now; brk_req && auto_dead_time_disable && !dead_time_active |=> brake_on; endproperty
    a_brk_now: assert property (p_brk_now) else $error("brake not applied");
    property p_brk_off; !brk_req && !dead_time_active |=> !brake_on; endproperty
    a_brk_off: assert property (p_brk_off) else $error("brake without request");
    property p_dir;
        auto_dead_time_disable && !dead_time_active && !brk_req
            |=> dir_ccw == $past(rotation_direction_pin ^ dir_invert);
    endproperty
    a_dir: assert property (p_dir) else $error("direction mapping wrong");
    property p_clamp;
        lead_angle_eff <= (comm_angle_sel == 2'h0 ? 3'h4 : comm_angle_sel == 2'h1 ? 3'h3 : 3'h2);
    endproperty
    a_clamp: assert property (p_clamp) else $error("lead angle above clamp");
    property p_dt_len; $rose(dead_time_active) |-> dead_time_active [*8]; endproperty
    a_dt_len: assert property (p_dt_len) else $error("dead time too short");
endmodule
bind bcp_ctrl bcp_ctrl_chk chk_u (.clk_sys(clk_sys), .rst(rst), .brake_pin(brake_pin),
    .brake_polarity(brake_polarity), .auto_dead_time_disable(auto_dead_time_disable),
    .rotation_direction_pin(rotation_direction_pin), .dir_invert(dir_invert), .gate_hi(gate_hi),
    .gate_lo(gate_lo), .lead_angle_eff(lead_angle_eff), .comm_angle_sel(comm_angle_sel),
    .dir_ccw(dir_ccw), .brake_on(brake_on), .dead_time_active(dead_time_active),
    .current_limit_level(current_limit_level), .monitor_gain_sel(monitor_gain_sel));

// File: tb/bcp_inverter.sv
// six-switch inverter seen by the gate outputs
// assumes gate bits are active high, bit0 is phase u
`timescale 1ns/1ns
module bcp_inverter (
    input wire [2:0] gate_hi,
    input wire [2:0] gate_lo,
    output wire shoot_through
);
    // both switches of one leg on shorts the supply
    assign shoot_through = |(gate_hi & gate_lo);
endmodule

// File: tb/bcp_tb.sv
// self-checking bench for bcp_ctrl with inverter model
// assumes the register map header is on the include path
`timescale 1ns/1ns
`include "bcp_map.vh"
module testbench;
    localparam INT_DIV = 21;
    localparam STEP = 50;
    reg clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, closed_loop = 1'b0, duty_up_slow = 1'b0;
    reg comm_event = 1'b0, rotation_direction_pin = 1'b0, dir_invert = 1'b0;
    reg brake_pin = 1'b0, brake_polarity = 1'b0, auto_dead_time_disable = 1'b0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    reg [1:0] phase_state = 2'h0;
    reg [9:0] duty_target = 10'h000;
    reg [2:0] duty_step_limit = 3'h0, ss_duty_step_limit = 3'h0, comm_step = 3'h0, lead_angle_req = 3'h7;
    reg [15:0] elec_freq_hz = 16'h0000;
    wire [7:0] reg_rdata;
    wire [2:0] gate_hi, gate_lo, lead_angle_eff, speed_band, gate_source_code, gate_sink_code;
    wire [9:0] duty_out;
    wire [1:0] comm_angle_sel, carrier_div_sel;
    wire soft_switch_on, dir_ccw, brake_on, dead_time_active, current_limit_level, monitor_gain_sel, shoot;
    integer num_errors = 0, n_compared = 0, cyc = 0, i, n;
    always #2 clk_sys = ~clk_sys;
    bcp_ctrl #(.STEP_FAST_CYC(STEP), .STEP_SLOW_CYC(4 * STEP), .INT_DIV(INT_DIV)) dut_u (.clk_sys(clk_sys),
        .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .phase_state(phase_state), .closed_loop(closed_loop), .duty_target(duty_target),
        .duty_step_limit(duty_step_limit), .ss_duty_step_limit(ss_duty_step_limit),
        .duty_up_slow(duty_up_slow), .elec_freq_hz(elec_freq_hz), .comm_step(comm_step),
        .comm_event(comm_event), .lead_angle_req(lead_angle_req),
        .rotation_direction_pin(rotation_direction_pin), .dir_invert(dir_invert), .brake_pin(brake_pin),
        .brake_polarity(brake_polarity), .auto_dead_time_disable(auto_dead_time_disable),
        .gate_hi(gate_hi), .gate_lo(gate_lo), .duty_out(duty_out), .lead_angle_eff(lead_angle_eff),
        .comm_angle_sel(comm_angle_sel), .soft_switch_on(soft_switch_on), .dir_ccw(dir_ccw),
        .brake_on(brake_on), .dead_time_active(dead_time_active), .carrier_div_sel(carrier_div_sel),
        .speed_band(speed_band), .gate_source_code(gate_source_code), .gate_sink_code(gate_sink_code),
        .current_limit_level(current_limit_level), .monitor_gain_sel(monitor_gain_sel));
    bcp_inverter inv_u (.gate_hi(gate_hi), .gate_lo(gate_lo), .shoot_through(shoot));
    task chk(input [9:0] got, input [9:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge clk_sys) reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        reg_addr = a;
        repeat (2) @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask
    task wt_div(input [1:0] exp);
        n = 0;
        while (carrier_div_sel !== exp && n < 12000) begin
            @(negedge clk_sys) n = n + 1;
        end
        chk(carrier_div_sel, exp);
    endtask
    task t_regs;
        reg [1:0] sel;
        wr(`BCP_ADDR_GATE, 8'h6b);
        rd(`BCP_ADDR_GATE, 8'h6b);
        chk(gate_source_code, 3'h5);
        chk(gate_sink_code, 3'h3);
        chk({current_limit_level, monitor_gain_sel}, 2'h3);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        rd(`BCP_ADDR_GATE, 8'h6b);
        for (i = 0; i < 8; i = i + 1) begin
            wr(`BCP_ADDR_COMM, {i[2:0], 5'h00});
            sel = (i[1:0] == 2'h2) ? 2'h3 : (i[1:0] == 2'h3) ? {1'b1, i[2]} : i[1:0];
            chk(comm_angle_sel, sel);
            chk(soft_switch_on, !i[2] && i[1:0] != 2'h0);
            chk(lead_angle_eff, sel == 2'h0 ? 3'h4 : sel == 2'h1 ? 3'h3 : 3'h2);
        end
        $display("regs test done");
    endtask
    task t_dir;
        auto_dead_time_disable = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            {dir_invert, rotation_direction_pin} = i[1:0];
            repeat (2) @(negedge clk_sys);
            chk(dir_ccw, i[0] ^ i[1]);
        end
        auto_dead_time_disable = 1'b0;
        rotation_direction_pin = 1'b0;
        @(negedge clk_sys) chk(dead_time_active, 1'b1);
        repeat (80) @(negedge clk_sys);
        chk(dir_ccw, 1'b1);
        $display("direction test done");
    endtask
    task t_brake;
        brake_polarity = 1'b1; brake_pin = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`BCP_ADDR_COMM, {6'h00, i[1:0]});
            brake_pin = 1'b0;
            @(negedge clk_sys) chk(dead_time_active, 1'b1);
            n = 0;
            while (!brake_on && n < 500) begin
                @(negedge clk_sys) n = n + 1;
            end
            // dead time 3, 6, 12, 18 internal ticks
            chk(n >= ((i == 3) ? 17 : (3 << i) - 1) * INT_DIV + 1 && n <= ((i == 3) ? 18 : 3 << i) * INT_DIV, 1'b1);
            @(negedge clk_sys) chk(gate_lo, 3'h7);
            brake_pin = 1'b1;
            repeat (2) @(negedge clk_sys) chk(brake_on, 1'b0);
        end
        $display("brake test done");
    endtask
    task t_duty;
        closed_loop = 1'b1; duty_step_limit = 3'h7; duty_target = 10'd512; phase_state = 2'h2;
        n = 0;
        while (duty_out === 10'h000 && n < 300) begin
            @(negedge clk_sys) n = n + 1;
        end
        chk(duty_out, 10'd7);
        repeat (STEP) @(negedge clk_sys);
        chk(duty_out, 10'd14);
        duty_up_slow = 1'b1;
        repeat (4 * STEP - 1) @(negedge clk_sys);
        chk(duty_out, 10'd14);
        @(negedge clk_sys) chk(duty_out, 10'd21);
        duty_up_slow = 1'b0;
        closed_loop = 1'b0;
        duty_step_limit = 3'h0;
        repeat (2) @(negedge clk_sys);
        chk(duty_out, 10'd512);
        phase_state = 2'h0;
        repeat (2) @(negedge clk_sys);
        chk(duty_out, 10'h000);
        $display("duty test done");
    endtask
    task t_carrier;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`BCP_ADDR_COMM, {3'h0, i[2:0], 2'h0});
            wt_div(i[1:0]);
        end
        elec_freq_hz = 16'd1100;
        wr(`BCP_ADDR_COMM, 8'h1c);
        repeat (10) @(negedge clk_sys);
        chk(speed_band, 3'h5);
        wt_div(2'h3);
        elec_freq_hz = 16'd950;
        repeat (10) @(negedge clk_sys);
        chk(speed_band, 3'h5);
        elec_freq_hz = 16'd850;
        repeat (10) @(negedge clk_sys);
        chk(speed_band, 3'h4);
        wr(`BCP_ADDR_COMM, 8'h14);
        wt_div(2'h2);
        $display("carrier test done");
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (shoot === 1'b1) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: leg shorted", $time);
        end
        if (cyc == 90000) begin
            num_errors = num_errors + 1;
            complete_run;
        end
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        t_regs;
        t_dir;
        t_brake;
        t_duty;
        t_carrier;
        complete_run;
    end
endmodule
